// ### hdl/brmc_access_arb.sv
// Access arbitration between the serial port and the EEPROM controller.
// Purely combinational; the top registers everything it produces.
`timescale 1ns/1ps
`default_nettype none
module brmc_access_arb #(
   parameter int unsigned BUF_BYTES  = 256,
   parameter int unsigned STAT_BYTES = 16
) (
   input  wire logic        i_sp_wr,
   input  wire logic        i_sp_rd,
   input  wire logic [15:0] i_sp_addr,
   input  wire logic [7:0]  i_sp_wdata,
   input  wire logic        i_ee_busy,
   input  wire logic        i_ee_wr,
   input  wire logic        i_ee_rd,
   input  wire logic [15:0] i_ee_addr,
   input  wire logic [7:0]  i_ee_wdata,
   output logic             o_wr_en,
   output logic [15:0]      o_wr_addr,
   output logic [7:0]       o_wr_data,
   output logic             o_sp_rd_ok,
   output logic             o_ee_rd_ok
);
   brmc_pkg::brmc_attr_t sp_attr;
   brmc_pkg::brmc_attr_t ee_attr;
   logic                 sp_w_ok;
   logic                 ee_w_ok;

   assign sp_attr = brmc_pkg::brmc_decode(i_sp_addr, BUF_BYTES, STAT_BYTES);
   assign ee_attr = brmc_pkg::brmc_decode(i_ee_addr, BUF_BYTES, STAT_BYTES);

   // The EEPROM side owns regular registers only while it is busy.
   assign sp_w_ok = i_sp_wr && sp_attr.exist && !sp_attr.ro && !i_ee_busy;
   assign ee_w_ok = i_ee_wr && i_ee_busy && ee_attr.exist && !ee_attr.ro && !ee_attr.excl;

   assign o_wr_en    = sp_w_ok || ee_w_ok;
   assign o_wr_addr  = ee_w_ok ? i_ee_addr : i_sp_addr;
   assign o_wr_data  = ee_w_ok ? i_ee_wdata : i_sp_wdata;
   assign o_sp_rd_ok = i_sp_rd && sp_attr.exist && (sp_attr.ro || !i_ee_busy);
   assign o_ee_rd_ok = i_ee_rd && i_ee_busy && ee_attr.exist && !ee_attr.ro && !ee_attr.excl;
endmodule
`default_nettype wire

// ### hdl/brmc_pkg.sv
// Shared constants, attribute decode and class decode for the register bank.
// Assumes byte-wide accesses with 16-bit addresses from the serial port and EEPROM side.
package brmc_pkg;

   localparam logic [15:0] ADDR_LOW       = 16'h0000;
   localparam logic [15:0] ADDR_HIGH      = 16'h0E4F;
   localparam logic [15:0] ADDR_CTRL      = 16'h0000;
   localparam logic [15:0] ADDR_RBCTL     = 16'h0004;
   localparam logic [15:0] ADDR_UPDATE    = 16'h0005;
   localparam logic [15:0] ADDR_BUF_BASE  = 16'h0100;
   localparam logic [15:0] ADDR_STAT_BASE = 16'h0D00;
   localparam logic [15:0] ADDR_SEQ_BASE  = 16'h0E10;
   localparam logic [15:0] ADDR_SEQ_LAST  = 16'h0E4F;
   localparam int          SEQ_BYTES      = 64;

   localparam int          CTRL_SOFT_RESET_BIT = 5;
   localparam int          RBCTL_DISABLE_BIT   = 3;
   localparam int          RBCTL_READ_BUF_BIT  = 0;
   localparam int          UPDATE_BIT          = 0;

   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  RBCTL_RESET  = 8'h00;
   localparam logic        UPDATE_RESET = 1'b0;
   localparam logic [7:0]  BUF_RESET    = 8'h00;
   localparam logic [7:0]  SEQ_RESET    = 8'h00;

   // Bit positions of the write-detection class vector; address class 0x6 sets two bits.
   localparam int WD_FAULT  = 0;
   localparam int WD_UNLOCK = 1;
   localparam int WD_HOLD   = 2;
   localparam int WD_WDOG   = 3;
   localparam int WD_STAB   = 4;
   localparam int WD_FUNC   = 5;

   typedef struct packed {
      logic exist;
      logic ro;
      logic live;
      logic excl;
      logic buffered;
   } brmc_attr_t;

   typedef enum logic [2:0] {
      HO_IDLE   = 3'b001,
      HO_ARMED  = 3'b010,
      HO_ACTIVE = 3'b100
   } brmc_ho_state_t;

   // Read-only wins over every other class, so it is tested first.
   function automatic brmc_attr_t brmc_decode(input logic [15:0] a,
                                              input int unsigned nbuf,
                                              input int unsigned nstat);
      brmc_attr_t t;
      t = '0;
      if (a >= ADDR_STAT_BASE && a < ADDR_STAT_BASE + 16'(nstat))
      begin
         t.exist = 1'b1;
         t.ro    = 1'b1;
         t.live  = 1'b1;
         t.excl  = 1'b1;
      end
      else if (a >= ADDR_SEQ_BASE && a <= ADDR_SEQ_LAST)
      begin
         t.exist = 1'b1;
         t.live  = 1'b1;
      end
      else if (a >= ADDR_BUF_BASE && a < ADDR_BUF_BASE + 16'(nbuf))
      begin
         t.exist    = 1'b1;
         t.buffered = 1'b1;
      end
      else if (a == ADDR_CTRL)
      begin
         t.exist = 1'b1;
         t.live  = 1'b1;
         t.excl  = 1'b1;
      end
      else if (a == ADDR_RBCTL || a == ADDR_UPDATE)
      begin
         t.exist = 1'b1;
         t.live  = 1'b1;
      end
      return t;
   endfunction

   // Class of a buffered byte comes from address bits 7:4; 0x6 carries two classes.
   function automatic logic [5:0] brmc_wclass(input logic [15:0] a);
      case (a[7:4])
         4'h0:    return 6'h01;
         4'h1:    return 6'h02;
         4'h2:    return 6'h04;
         4'h3:    return 6'h08;
         4'h4:    return 6'h10;
         4'h5:    return 6'h20;
         4'h6:    return 6'h03;
         default: return 6'h00;
      endcase
   endfunction

endpackage

// ### hdl/brmc_top.sv
// Buffered register map: byte access, buffered and active copies, commit strobe,
// write-detection effects and arbitration between serial port and EEPROM controller.
// Assumes the serial port delivers decoded byte accesses in the system clock domain.
// Operation
// - Decode addresses 0x0000 to 0x0E4F, bytewise
// - Multi-byte values: LSB at lowest address
// - Sequence block stored bytewise, no ordering
// - Buffered copy takes writes, active copy controls
// - Writing one to update commits all
// - Live registers act as byte arrives
// - Readback bit three disables write detection
// - Fault class write faults reference immediately
// - Unlock class write forces unlock immediately
// - Holdover class: one phase detector cycle
// - Watchdog class change holds watchdog reset
// - Stability class change holds stability timer
// - Function class write stops running function
// - Autoclear bits clear after their action
// - Strictest of several classes applies
// - Denied reads return zero, writes dropped
// - One source owns regular registers
// - Busy EEPROM locks out serial port
// - Read-only always readable from serial port
// - Excluded and read-only never reach EEPROM
// - Writes to unmapped addresses do nothing
// - Live status reflects device state
`timescale 1ns/1ps
`default_nettype none
module brmc_top #(
   parameter int unsigned BUF_BYTES  = 256,
   parameter int unsigned STAT_BYTES = 16
) (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_sp_wr,
   input  wire logic                    i_sp_rd,
   input  wire logic [15:0]             i_sp_addr,
   input  wire logic [7:0]              i_sp_wdata,
   output logic [7:0]                   o_sp_rdata,
   output logic                         o_sp_rvalid,
   input  wire logic                    i_ee_busy,
   input  wire logic                    i_ee_wr,
   input  wire logic                    i_ee_rd,
   input  wire logic [15:0]             i_ee_addr,
   input  wire logic [7:0]              i_ee_wdata,
   output logic [7:0]                   o_ee_rdata,
   output logic                         o_ee_rvalid,
   input  wire logic [8*STAT_BYTES-1:0] i_status,
   input  wire logic                    i_func_running,
   input  wire logic                    i_pd_tick,
   output logic [8*BUF_BYTES-1:0]       o_active,
   output logic                         o_commit,
   output logic                         o_ref_fault,
   output logic                         o_unlock,
   output logic                         o_holdover,
   output logic                         o_wdog_hold,
   output logic                         o_stab_hold,
   output logic                         o_func_stop
);
   generate
      if (BUF_BYTES < 16 || BUF_BYTES > 256 || (BUF_BYTES & (BUF_BYTES - 1)) != 0)
      begin : g_bad_buf
         $error("BUF_BYTES must be a power of two from 16 to 256");
      end
      if (STAT_BYTES < 1 || STAT_BYTES > 16)
      begin : g_bad_stat
         $error("STAT_BYTES must be 1 to 16");
      end
   endgenerate

   logic [7:0]              ctrl_q;
   logic [7:0]              rbctl_q;
   logic                    upd_q;
   logic [8*BUF_BYTES-1:0]  buf_q;
   logic [7:0]              seq_q [0:brmc_pkg::SEQ_BYTES-1];
   logic [8*STAT_BYTES-1:0] stat_q;
   logic                    wr_en;
   logic [15:0]             wr_addr;
   logic [7:0]              wr_data;
   logic                    sp_rd_ok;
   logic                    ee_rd_ok;
   brmc_pkg::brmc_attr_t    wattr;
   brmc_pkg::brmc_attr_t    sp_attr;
   brmc_pkg::brmc_attr_t    ee_attr;
   logic [7:0]              widx;
   logic [5:0]              sidx;
   logic [5:0]              wcls;
   logic                    changed;
   logic                    soft_clr;

   brmc_access_arb #(
      .BUF_BYTES  (BUF_BYTES),
      .STAT_BYTES (STAT_BYTES)
   ) u_arb (
      .i_sp_wr    (i_sp_wr),
      .i_sp_rd    (i_sp_rd),
      .i_sp_addr  (i_sp_addr),
      .i_sp_wdata (i_sp_wdata),
      .i_ee_busy  (i_ee_busy),
      .i_ee_wr    (i_ee_wr),
      .i_ee_rd    (i_ee_rd),
      .i_ee_addr  (i_ee_addr),
      .i_ee_wdata (i_ee_wdata),
      .o_wr_en    (wr_en),
      .o_wr_addr  (wr_addr),
      .o_wr_data  (wr_data),
      .o_sp_rd_ok (sp_rd_ok),
      .o_ee_rd_ok (ee_rd_ok)
   );

   assign wattr    = brmc_pkg::brmc_decode(wr_addr, BUF_BYTES, STAT_BYTES);
   assign sp_attr  = brmc_pkg::brmc_decode(i_sp_addr, BUF_BYTES, STAT_BYTES);
   assign ee_attr  = brmc_pkg::brmc_decode(i_ee_addr, BUF_BYTES, STAT_BYTES);
   assign widx     = wr_addr[7:0];
   assign sidx     = 6'(wr_addr - brmc_pkg::ADDR_SEQ_BASE);
   assign wcls     = wattr.buffered ? brmc_pkg::brmc_wclass(wr_addr) : 6'h00;
   assign changed  = wr_data != buf_q[8*widx +: 8];
   assign soft_clr = ctrl_q[brmc_pkg::CTRL_SOFT_RESET_BIT];
   assign o_commit = upd_q;

   // Byte n of a group sits at bits 8n+7:8n, so the lowest address holds the LSB.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || soft_clr)
         buf_q <= {BUF_BYTES{brmc_pkg::BUF_RESET}};
      else if (wr_en && wattr.buffered)
         buf_q[8*widx +: 8] <= wr_data;
   end

   // The whole group moves at once so downstream never sees a half-updated set.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || soft_clr)
         o_active <= {BUF_BYTES{brmc_pkg::BUF_RESET}};
      else if (upd_q)
         o_active <= buf_q;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         upd_q <= brmc_pkg::UPDATE_RESET;
      else if (wr_en && wr_addr == brmc_pkg::ADDR_UPDATE)
         upd_q <= wr_data[brmc_pkg::UPDATE_BIT];
      else
         upd_q <= 1'b0;
   end

   // Soft reset clears both register copies and then clears itself.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         ctrl_q <= brmc_pkg::CTRL_RESET;
      else if (wr_en && wr_addr == brmc_pkg::ADDR_CTRL)
         ctrl_q <= wr_data;
      else if (soft_clr)
         ctrl_q[brmc_pkg::CTRL_SOFT_RESET_BIT] <= 1'b0;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         rbctl_q <= brmc_pkg::RBCTL_RESET;
      else if (wr_en && wr_addr == brmc_pkg::ADDR_RBCTL)
         rbctl_q <= wr_data;
   end

   // Sequence bytes are kept raw; their instruction format is the EEPROM side's business.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         for (int k = 0; k < brmc_pkg::SEQ_BYTES; k++)
            seq_q[k] <= brmc_pkg::SEQ_RESET;
      end
      else if (wr_en && wattr.live && wr_addr >= brmc_pkg::ADDR_SEQ_BASE)
         seq_q[sidx] <= wr_data;
   end

   // Status is resampled every cycle and has no write path at all.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         stat_q <= '0;
      else
         stat_q <= i_status;
   end

   // Reads see the active copy unless the read-buffer bit is set, so staged values can be checked.
   function automatic logic [7:0] rd_byte(input logic [15:0] a);
      brmc_pkg::brmc_attr_t t;
      logic [7:0]           v;
      t = brmc_pkg::brmc_decode(a, BUF_BYTES, STAT_BYTES);
      v = 8'h00;
      if (t.ro)
         v = stat_q[8*a[3:0] +: 8];
      else if (t.buffered)
         v = rbctl_q[brmc_pkg::RBCTL_READ_BUF_BIT] ? buf_q[8*a[7:0] +: 8]
                                                    : o_active[8*a[7:0] +: 8];
      else if (t.live && a >= brmc_pkg::ADDR_SEQ_BASE)
         v = seq_q[6'(a - brmc_pkg::ADDR_SEQ_BASE)];
      else if (a == brmc_pkg::ADDR_CTRL)
         v = ctrl_q;
      else if (a == brmc_pkg::ADDR_RBCTL)
         v = rbctl_q;
      else if (a == brmc_pkg::ADDR_UPDATE)
         v = {7'h00, upd_q};
      return v;
   endfunction

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         o_sp_rdata  <= 8'h00;
         o_sp_rvalid <= 1'b0;
      end
      else
      begin
         o_sp_rdata  <= sp_rd_ok ? rd_byte(i_sp_addr) : 8'h00;
         o_sp_rvalid <= i_sp_rd;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         o_ee_rdata  <= 8'h00;
         o_ee_rvalid <= 1'b0;
      end
      else
      begin
         o_ee_rdata  <= ee_rd_ok ? rd_byte(i_ee_addr) : 8'h00;
         o_ee_rvalid <= i_ee_rd;
      end
   end

   brmc_write_detect u_wdet (
      .i_clk_sys      (i_clk_sys),
      .i_rst_n        (i_rst_n),
      .i_wr_en        (wr_en),
      .i_cls          (wcls),
      .i_changed      (changed),
      .i_enable       (!rbctl_q[brmc_pkg::RBCTL_DISABLE_BIT]),
      .i_func_running (i_func_running),
      .i_commit       (upd_q),
      .i_pd_tick      (i_pd_tick),
      .o_ref_fault    (o_ref_fault),
      .o_unlock       (o_unlock),
      .o_holdover     (o_holdover),
      .o_wdog_hold    (o_wdog_hold),
      .o_stab_hold    (o_stab_hold),
      .o_func_stop    (o_func_stop)
   );

   chk_commit_copy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (upd_q && !soft_clr) |=> (o_active == $past(buf_q)))
      else $error("active copy differs from buffer after commit");
   chk_active_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (!upd_q && !soft_clr) |=> $stable(o_active))
      else $error("active copy changed without commit");
   chk_update_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (upd_q && !(wr_en && wr_addr == brmc_pkg::ADDR_UPDATE)) |=> !upd_q)
      else $error("update bit did not autoclear");
   chk_denied_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_sp_rd && !sp_rd_ok) |=> (o_sp_rvalid && o_sp_rdata == 8'h00))
      else $error("denied read returned nonzero");
   chk_busy_lockout: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ee_busy && i_sp_wr && !i_ee_wr) |-> !wr_en)
      else $error("serial write accepted while EEPROM busy");
   chk_ro_readable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_sp_rd && sp_attr.ro) |-> sp_rd_ok)
      else $error("read-only register refused to serial port");
   chk_ee_excluded: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ee_rd && (ee_attr.excl || ee_attr.ro)) |-> !ee_rd_ok)
      else $error("excluded register reached EEPROM");
   chk_live_rbctl: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (wr_en && wr_addr == brmc_pkg::ADDR_RBCTL) |=> (rbctl_q == $past(wr_data)))
      else $error("live register did not take written byte");
   chk_status_live: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      1'b1 |=> (stat_q == $past(i_status)))
      else $error("status not following device state");
   chk_unmapped_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_sp_wr && !sp_attr.exist && !i_ee_wr) |-> !wr_en)
      else $error("write to unmapped address accepted");
   chk_ro_write_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_sp_wr && sp_attr.ro && !i_ee_wr) |-> !wr_en)
      else $error("write to read-only register accepted");
   chk_soft_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (soft_clr && !(wr_en && wr_addr == brmc_pkg::ADDR_CTRL)) |=> (!soft_clr && buf_q == '0))
      else $error("soft reset left buffer or its own bit set");

   cov_commit: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) upd_q);
   cov_busy_deny: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_ee_busy && i_sp_rd && !sp_rd_ok);
   cov_fault_commit: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_ref_fault ##[1:20] !o_ref_fault);
   cov_soft_reset: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) soft_clr);
endmodule
`default_nettype wire

// ### hdl/brmc_write_detect.sv
// Write-detection side effects toward reference monitor, lock detector and timers.
// Expects one-cycle write strobes, a commit pulse and a phase detector tick enable.
`timescale 1ns/1ps
`default_nettype none
module brmc_write_detect (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_wr_en,
   input  wire logic [5:0] i_cls,
   input  wire logic       i_changed,
   input  wire logic       i_enable,
   input  wire logic       i_func_running,
   input  wire logic       i_commit,
   input  wire logic       i_pd_tick,
   output logic            o_ref_fault,
   output logic            o_unlock,
   output logic            o_holdover,
   output logic            o_wdog_hold,
   output logic            o_stab_hold,
   output logic            o_func_stop
);
   logic [5:0]                hit;
   logic                      hold_pend;
   brmc_pkg::brmc_ho_state_t  ho_st;

   assign hit = (i_wr_en && i_enable) ? i_cls : 6'h00;

   // A write in the commit cycle re-arms the flag: set wins over the release.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         o_ref_fault <= 1'b0;
         o_unlock    <= 1'b0;
         o_wdog_hold <= 1'b0;
         o_stab_hold <= 1'b0;
         o_func_stop <= 1'b0;
      end
      else
      begin
         if (hit[brmc_pkg::WD_FAULT])
            o_ref_fault <= 1'b1;
         else if (i_commit)
            o_ref_fault <= 1'b0;
         if (hit[brmc_pkg::WD_UNLOCK])
            o_unlock <= 1'b1;
         else if (i_commit)
            o_unlock <= 1'b0;
         if (hit[brmc_pkg::WD_WDOG] && i_changed)
            o_wdog_hold <= 1'b1;
         else if (i_commit)
            o_wdog_hold <= 1'b0;
         if (hit[brmc_pkg::WD_STAB] && i_changed)
            o_stab_hold <= 1'b1;
         else if (i_commit)
            o_stab_hold <= 1'b0;
         if (hit[brmc_pkg::WD_FUNC] && i_func_running)
            o_func_stop <= 1'b1;
         else if (i_commit)
            o_func_stop <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         hold_pend <= 1'b0;
      else if (hit[brmc_pkg::WD_HOLD])
         hold_pend <= 1'b1;
      else if (i_commit && ho_st == brmc_pkg::HO_IDLE)
         hold_pend <= 1'b0;
   end

   // Holdover spans from one phase detector tick to the next.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         ho_st      <= brmc_pkg::HO_IDLE;
         o_holdover <= 1'b0;
      end
      else
      begin
         unique case (ho_st)
            brmc_pkg::HO_IDLE:
               if (i_commit && hold_pend)
                  ho_st <= brmc_pkg::HO_ARMED;
            brmc_pkg::HO_ARMED:
               if (i_pd_tick)
               begin
                  ho_st      <= brmc_pkg::HO_ACTIVE;
                  o_holdover <= 1'b1;
               end
            brmc_pkg::HO_ACTIVE:
               if (i_pd_tick)
               begin
                  ho_st      <= brmc_pkg::HO_IDLE;
                  o_holdover <= 1'b0;
               end
            default:
            begin
               ho_st      <= brmc_pkg::HO_IDLE;
               o_holdover <= 1'b0;
            end
         endcase
      end
   end

   chk_fault_on_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr_en && i_enable && i_cls[brmc_pkg::WD_FAULT]) |=> o_ref_fault)
      else $error("reference fault not raised on write");
   chk_disable_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (!i_enable && !o_unlock) |=> !o_unlock)
      else $error("unlock raised while write detection disabled");
   chk_holdover_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_holdover && !i_pd_tick) |=> o_holdover)
      else $error("holdover dropped before phase detector tick");
   chk_holdover_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_holdover && i_pd_tick) |=> !o_holdover)
      else $error("holdover longer than one phase detector cycle");
   chk_wdog_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_wdog_hold && i_commit && !hit[brmc_pkg::WD_WDOG]) |=> !o_wdog_hold)
      else $error("watchdog not released at commit");
   cov_holdover: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_holdover));
endmodule
`default_nettype wire

// ### verification/brmc_host_model.sv
// Host on the serial port: one-cycle byte strobes driven at the falling edge.
// Assumes the bench owns the clock and calls the tasks after reset release.
`timescale 1ns/1ps
`default_nettype none
module brmc_host_model (
   input  wire logic        i_clk_sys,
   input  wire logic [7:0]  i_rdata,
   input  wire logic        i_rvalid,
   output logic             o_wr,
   output logic             o_rd,
   output logic [15:0]      o_addr,
   output logic [7:0]       o_wdata
);
   initial
   begin
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_addr  = 16'h0000;
      o_wdata = 8'h00;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clk_sys);
      o_wr    = 1'b0;
      // Released data is inverted so a late sample cannot pass by luck.
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic v, output logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clk_sys);
      v    = i_rvalid;
      d    = i_rdata;
      o_rd = 1'b0;
   endtask
   task automatic commit();
      wr(16'h0005, 8'h01);
   endtask
   task automatic mute();
      wr(16'h0004, 8'h08);
   endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the buffered register map, driven through the host model.
// Assumes the default map sizes; the bench itself plays the EEPROM controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic          clk_sys = 1'b0;
   logic          rst_n = 1'b0;
   logic          busy = 1'b0;
   logic          frun = 1'b0;
   logic          tick = 1'b0;
   logic          ee_wr = 1'b0;
   logic          ee_rd = 1'b0;
   logic [15:0]   ee_addr = 16'h0000;
   logic [7:0]    ee_wd = 8'h00;
   logic          erv;
   logic [7:0]    erd;
   logic          wr, rd, rv, cm, rf, ul, ho, wh, sh, fs;
   logic [15:0]   addr;
   logic [7:0]    wd, rdt;
   logic [2047:0] act;
   int            failures = 0;
   int            cmp_count = 0;
   always #10 clk_sys = ~clk_sys;
   brmc_host_model h (.i_clk_sys(clk_sys), .i_rdata(rdt), .i_rvalid(rv), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wd));
   brmc_top dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_sp_wr(wr), .i_sp_rd(rd),
      .i_sp_addr(addr), .i_sp_wdata(wd), .o_sp_rdata(rdt), .o_sp_rvalid(rv),
      .i_ee_busy(busy), .i_ee_wr(ee_wr), .i_ee_rd(ee_rd), .i_ee_addr(ee_addr),
      .i_ee_wdata(ee_wd), .o_ee_rdata(erd), .o_ee_rvalid(erv), .i_status({120'h0, 8'h5A}),
      .i_func_running(frun), .i_pd_tick(tick), .o_active(act), .o_commit(cm),
      .o_ref_fault(rf), .o_unlock(ul), .o_holdover(ho), .o_wdog_hold(wh),
      .o_stab_hold(sh), .o_func_stop(fs));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string n);
      logic       v;
      logic [7:0] d;
      h.rd(a, v, d);
      chk("rvalid", 8'h01, {7'h00, v});
      chk(n, e, d);
   endtask
   task automatic ee_op(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      ee_wr   = w;
      ee_rd   = !w;
      ee_addr = a;
      ee_wd   = d;
      @(negedge clk_sys);
      ee_wr = 1'b0;
      ee_rd = 1'b0;
      if (!w)
      begin
         chk("ee_rvalid", 8'h01, {7'h00, erv});
         chk("ee_rd", d, erd);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic finish_test();
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_commit();
      h.wr(16'h0105, 8'hAB);
      chk("ref_fault", 8'h01, {7'h00, rf});
      chk("active5", 8'h00, act[47:40]);
      rchk(16'h0105, 8'h00, "active_rd");
      h.commit();
      chk("commit", 8'h01, {7'h00, cm});
      chk("active5", 8'h00, act[47:40]);
      wait_n(1);
      chk("active5", 8'hAB, act[47:40]);
      rchk(16'h0005, 8'h00, "update_rd");
      chk("ref_fault", 8'h00, {7'h00, rf});
      rchk(16'h0105, 8'hAB, "active_rd");
   endtask
   task automatic t_denied();
      busy = 1'b1;
      h.wr(16'h0106, 8'h55);
      rchk(16'h0106, 8'h00, "busy_rd");
      rchk(16'h0D00, 8'h5A, "status_rd");
      busy = 1'b0;
      h.wr(16'h0D00, 8'hFF);
      h.wr(16'h0E50, 8'h77);
      rchk(16'h0D00, 8'h5A, "status_rd");
      rchk(16'h0E50, 8'h00, "unmapped_rd");
      h.commit();
      wait_n(2);
      chk("active6", 8'h00, act[55:48]);
   endtask
   task automatic t_holdover();
      h.wr(16'h0120, 8'h01);
      h.commit();
      wait_n(2);
      chk("holdover", 8'h00, {7'h00, ho});
      tick = 1'b1;
      wait_n(1);
      tick = 1'b0;
      wait_n(3);
      chk("holdover", 8'h01, {7'h00, ho});
      tick = 1'b1;
      wait_n(1);
      tick = 1'b0;
      chk("holdover", 8'h00, {7'h00, ho});
   endtask
   task automatic t_classes();
      h.wr(16'h0130, 8'h00);
      chk("wdog", 8'h00, {7'h00, wh});
      h.wr(16'h0130, 8'h05);
      chk("wdog", 8'h01, {7'h00, wh});
      h.wr(16'h0140, 8'h07);
      chk("stab", 8'h01, {7'h00, sh});
      frun = 1'b1;
      h.wr(16'h0150, 8'h03);
      chk("func_stop", 8'h01, {7'h00, fs});
      h.wr(16'h0160, 8'h01);
      chk("flags", 8'h03, {6'h00, ul, rf});
      h.commit();
      wait_n(3);
      chk("flags", 8'h00, {3'h0, ul, rf, wh, sh, fs});
      h.mute();
      h.wr(16'h0110, 8'h09);
      chk("unlock", 8'h00, {7'h00, ul});
   endtask
   task automatic t_eeprom();
      busy = 1'b1;
      ee_op(1'b1, 16'h0E10, 8'h3C);
      ee_op(1'b1, 16'h0000, 8'h40);
      ee_op(1'b0, 16'h0E10, 8'h3C);
      ee_op(1'b0, 16'h0D00, 8'h00);
      rchk(16'h0E10, 8'h00, "busy_rd");
      busy = 1'b0;
      rchk(16'h0E10, 8'h3C, "seq_rd");
      rchk(16'h0000, 8'h00, "ctrl_rd");
   endtask
   task automatic t_modes();
      h.wr(16'h0004, 8'h09);
      h.wr(16'h0107, 8'h66);
      rchk(16'h0107, 8'h66, "buffer_rd");
      chk("active7", 8'h00, act[63:56]);
      h.wr(16'h0000, 8'h20);
      rchk(16'h0105, 8'h00, "soft_rd");
      rchk(16'h0000, 8'h00, "ctrl_rd");
      chk("active5", 8'h00, act[47:40]);
   endtask
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      finish_test();
   end
   initial
   begin
      wait_n(12);
      rst_n = 1'b1;
      t_commit();
      t_denied();
      t_holdover();
      t_classes();
      t_eeprom();
      t_modes();
      finish_test();
   end
endmodule
`default_nettype wire
